// ===== pkg/idr_pkg.sv
// Purpose: Shared constants and types for the input diagnostic record tail.
// Assumes: 100 MHz core clock, record read one byte at a time.
// Notes:   Record byte indices follow the record order of the module.
package idr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Record byte indices
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_DIAG_SUMMARY = 5'h00;
  localparam logic [4:0] OFS_MODULE_INFO = 5'h01;
  localparam logic [4:0] OFS_RSVD_C = 5'h02;
  localparam logic [4:0] OFS_DIAG_EXTRA = 5'h03;
  localparam logic [4:0] OFS_CHANNEL_TYPE = 5'h04;
  localparam logic [4:0] OFS_DIAG_BITS_PER_CHANNEL = 5'h05;
  localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] OFS_LOST_EDGE_FLAGS = 5'h07;
  localparam logic [4:0] OFS_PER_CHANNEL_RESERVED_FIRST = 5'h08;
  localparam logic [4:0] OFS_PER_CHANNEL_RESERVED_LAST = 5'h0f;
  localparam logic [4:0] OFS_DIAG_TIMESTAMP = 5'h10;
  localparam logic [4:0] OFS_LAST = 5'h13;

  // ----------------------------------------------------------------
  // Fixed values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] VAL_MODULE_INFO = 8'h1f;
  localparam logic [7:0] VAL_CHANNEL_TYPE = 8'h70;
  localparam logic [7:0] VAL_DIAG_BITS_PER_CHANNEL = 8'h00;
  localparam logic [7:0] VAL_CHANNEL_COUNT = 8'h04;
  localparam logic [7:0] VAL_ZERO = 8'h00;
  localparam int BIT_MODULE_FAIL = 0;
  localparam int BIT_EXT_ERROR = 2;
  localparam int BIT_CHANNEL_ERROR = 3;
  localparam int NUM_CHANNELS = 4;
  localparam logic [31:0] TICKER_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_QUIET  = 2'b01,
    ST_ACTIVE = 2'b10
  } idr_state_type;

  typedef struct packed {
    logic       module_fail;
    logic       ext_error;
    logic [3:0] lost_edge;
  } idr_cause_type;

  typedef struct packed {
    logic       stb;
    logic [4:0] addr;
  } idr_read_req_type;

endpackage

// ===== design/idr_us_ticker.sv
// Purpose: Free-running microsecond ticker.
// Assumes: Core clock period given by the package.
// Notes:   Prescaler divides the core clock down to one step per microsecond.
`timescale 1ns/1ns
`default_nettype none
module idr_us_ticker
  import idr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  output logic      [31:0] o_us
);

  typedef struct packed {
    logic [6:0]  prescale;
    logic [31:0] count;
  } idr_tick_state_type;

  idr_tick_state_type state_q;
  idr_tick_state_type state_d;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (state_q.prescale == TICK_LAST) begin
      state_d.prescale = 7'h00;
      // Plain 32-bit add rolls over to zero by itself
      state_d.count = state_q.count + 32'h0000_0001;
    end else begin
      state_d.prescale = state_q.prescale + 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q.prescale <= 7'h00;
      state_q.count <= TICKER_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_us = state_q.count;

endmodule // idr_us_ticker
`default_nettype wire

// ===== design/idr_diag_record.sv
// Purpose: Tail of the diagnostic record of a four-channel input module.
// Assumes: Cause inputs come from logic on the same clock; reads are
//          single-byte requests from the backplane side.
// Notes:   The record is read only; there is no write path at all.
//          Cause inputs are levels; the record is frozen while a
//          diagnostic is active, so later channel events are lost.
`timescale 1ns/1ns
`default_nettype none
module idr_diag_record
  import idr_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  input  wire logic        I_MODULE_FAIL,
  input  wire logic        I_EXT_ERROR,
  input  wire logic  [3:0] I_LOST_EDGE,
  input  wire logic        I_RD_STB,
  input  wire logic  [4:0] I_RD_ADDR,
  output logic       [7:0] O_RD_DATA,
  output logic             O_RD_VALID,
  output logic             O_DIAG_INCOMING,
  output logic             O_DIAG_GOING,
  output logic             O_MODULE_FAULT_LAMP,
  output logic      [31:0] O_US_TICKER
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Everything the block remembers, except the ticker prescale and count in u_ticker, sits in one struct
  typedef struct packed {
    idr_state_type mode;
    logic [3:0]    lost_edge_flags;
    logic          module_fail;
    logic          ext_error;
    logic [31:0]   diag_timestamp;
    logic [7:0]    rd_data;
    logic          rd_valid;
    logic          incoming;
    logic          going;
  } idr_core_state_type;

  idr_core_state_type state_q;
  idr_core_state_type state_d;
  idr_cause_type      cause;
  idr_read_req_type   rd_req;
  logic [31:0]        us_now;
  logic               cause_present;
  logic               raise_now;
  logic               clear_now;
  logic [7:0]         rd_byte;

  // ----------------------------------------------------------------
  // Ticker
  // ----------------------------------------------------------------
  // Ticker runs from reset on its own; nothing here stops or presets it
  idr_us_ticker u_ticker (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .o_us    (us_now)
  );

  // ----------------------------------------------------------------
  // Cause and request carriers
  // ----------------------------------------------------------------
  // Causes are same-clock levels, so no synchroniser is needed
  assign cause.module_fail = I_MODULE_FAIL;
  assign cause.ext_error = I_EXT_ERROR;
  assign cause.lost_edge = I_LOST_EDGE;
  assign rd_req.stb = I_RD_STB;
  assign rd_req.addr = I_RD_ADDR;
  assign cause_present = cause.module_fail | cause.ext_error | (|cause.lost_edge);

  // ----------------------------------------------------------------
  // Diagnostic window decode
  // ----------------------------------------------------------------
  assign raise_now = (state_q.mode == ST_QUIET) && cause_present;
  assign clear_now = (state_q.mode == ST_ACTIVE) && !cause_present;

  // ----------------------------------------------------------------
  // Index decoding
  // ----------------------------------------------------------------
  // Inclusive on both ends; shared by the reserved and stamp ranges
  function automatic logic index_in(input logic [4:0] addr,
                                    input logic [4:0] lo,
                                    input logic [4:0] hi);
    return (addr >= lo) && (addr <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Timestamp bytes
  // ----------------------------------------------------------------
  function automatic logic [7:0] ts_byte(input logic [31:0] ts, input logic [1:0] idx);
    logic [7:0] b;
    // Most significant byte first, at the lowest stamp index
    unique case (idx)
      2'h0: b = ts[31:24];
      2'h1: b = ts[23:16];
      2'h2: b = ts[15:8];
      default: b = ts[7:0];
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Summary byte
  // ----------------------------------------------------------------
  function automatic logic [7:0] summary_byte(input idr_core_state_type s);
    logic [7:0] b;
    // Bit 1 and the upper nibble are reserved and stay clear
    b = VAL_ZERO;
    b[BIT_MODULE_FAIL] = s.module_fail;
    b[BIT_EXT_ERROR] = s.ext_error;
    b[BIT_CHANNEL_ERROR] = |s.lost_edge_flags;
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Record map
  // ----------------------------------------------------------------
  // Unmapped indices fall through to zero, so a stray read is harmless
  function automatic logic [7:0] record_byte(input idr_core_state_type s,
                                             input logic [4:0] addr);
    logic [7:0] b;
    b = VAL_ZERO;
    if (addr == OFS_DIAG_SUMMARY) begin
      b = summary_byte(s);
    end else if (addr == OFS_MODULE_INFO) begin
      b = VAL_MODULE_INFO;
    end else if (addr == OFS_CHANNEL_TYPE) begin
      b = VAL_CHANNEL_TYPE;
    end else if (addr == OFS_DIAG_BITS_PER_CHANNEL) begin
      b = VAL_DIAG_BITS_PER_CHANNEL;
    end else if (addr == OFS_CHANNEL_COUNT) begin
      b = VAL_CHANNEL_COUNT;
    end else if (addr == OFS_LOST_EDGE_FLAGS) begin
      // Upper nibble is reserved and stays clear
      b = {4'h0, s.lost_edge_flags};
    end else if (index_in(addr, OFS_PER_CHANNEL_RESERVED_FIRST,
                          OFS_PER_CHANNEL_RESERVED_LAST)) begin
      b = VAL_ZERO;
    end else if (index_in(addr, OFS_DIAG_TIMESTAMP, OFS_LAST)) begin
      b = ts_byte(s.diag_timestamp, addr[1:0]);
    end
    return b;
  endfunction

  // Decoded from the registered record, so a read sees the state before its edge
  assign rd_byte = record_byte(state_q, rd_req.addr);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.incoming = 1'b0;
    state_d.going = 1'b0;
    // A held strobe gives one answer per cycle, back to back
    state_d.rd_valid = rd_req.stb;
    if (rd_req.stb) begin
      state_d.rd_data = rd_byte;
    end

    // Diagnostic window
    unique case (state_q.mode)
      ST_QUIET: begin
        if (raise_now) begin
          // Record is frozen at the incoming moment
          state_d.mode = ST_ACTIVE;
          state_d.incoming = 1'b1;
          state_d.lost_edge_flags = cause.lost_edge;
          state_d.module_fail = cause.module_fail;
          state_d.ext_error = cause.ext_error;
          state_d.diag_timestamp = us_now;
        end
      end
      ST_ACTIVE: begin
        // New channel events in this window are dropped on purpose,
        // so the record keeps describing the incoming event
        if (clear_now) begin
          // Stamp is kept after going, so the last event stays readable
          state_d.mode = ST_QUIET;
          state_d.going = 1'b1;
          state_d.lost_edge_flags = 4'h0;
          state_d.module_fail = 1'b0;
          state_d.ext_error = 1'b0;
        end
      end
      default: begin
        // An illegal code falls back to quiet rather than locking up
        state_d.mode = ST_QUIET;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      // Every field back to its idle value
      state_q.mode <= ST_QUIET;
      state_q.lost_edge_flags <= 4'h0;
      state_q.module_fail <= 1'b0;
      state_q.ext_error <= 1'b0;
      state_q.diag_timestamp <= TICKER_RESET;
      state_q.rd_data <= VAL_ZERO;
      state_q.rd_valid <= 1'b0;
      state_q.incoming <= 1'b0;
      state_q.going <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Data outputs come straight from flops
  assign O_RD_DATA = state_q.rd_data;
  assign O_RD_VALID = state_q.rd_valid;
  assign O_DIAG_INCOMING = state_q.incoming;
  assign O_DIAG_GOING = state_q.going;
  // Lamp is a decode of the mode flop, so it never lags the window
  assign O_MODULE_FAULT_LAMP = (state_q.mode == ST_ACTIVE);
  assign O_US_TICKER = us_now;

endmodule // idr_diag_record
`default_nettype wire

// ===== test/idr_diag_record_sva.sv
// Purpose: Port checks of the record tail
// Assumes: One clock, sync high reset
// Notes:   Stamp content is judged by the bench
`timescale 1ns/1ns
`default_nettype none
module idr_diag_record_chk
  import idr_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RESET,
  input wire logic        I_MODULE_FAIL,
  input wire logic        I_EXT_ERROR,
  input wire logic [3:0]  I_LOST_EDGE,
  input wire logic        I_RD_STB,
  input wire logic [4:0]  I_RD_ADDR,
  input wire logic [7:0]  O_RD_DATA,
  input wire logic        O_RD_VALID,
  input wire logic        O_DIAG_INCOMING,
  input wire logic        O_DIAG_GOING,
  input wire logic        O_MODULE_FAULT_LAMP,
  input wire logic [31:0] O_US_TICKER
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic cause;
  assign cause = I_MODULE_FAIL | I_EXT_ERROR | (|I_LOST_EDGE);
  chk_read_answer: assert property (I_RD_STB |=> O_RD_VALID)
    else $error("read not answered");
  chk_bits_const: assert property (
    I_RD_STB && I_RD_ADDR == 5'h05 |=> O_RD_DATA == 8'h00) else $error("bits byte");
  chk_count_const: assert property (
    I_RD_STB && I_RD_ADDR == 5'h06 |=> O_RD_DATA == 8'h04) else $error("count byte");
  chk_flags_upper: assert property (
    I_RD_STB && I_RD_ADDR == 5'h07 |=> O_RD_DATA[7:4] == 4'h0) else $error("flag bits");
  chk_rsvd_zero: assert property (
    I_RD_STB && I_RD_ADDR inside {[5'h08:5'h0f], [5'h14:5'h1f]} |=> O_RD_DATA == 8'h00)
    else $error("reserved byte");
  chk_tick_step: assert property (
    $changed(O_US_TICKER) |-> O_US_TICKER == $past(O_US_TICKER) + 32'h1) else $error("tick");
  chk_diag_raise: assert property (
    !O_MODULE_FAULT_LAMP && !O_DIAG_GOING && cause |=> O_DIAG_INCOMING && O_MODULE_FAULT_LAMP)
    else $error("no incoming");
  chk_diag_clear: assert property (
    O_MODULE_FAULT_LAMP && !cause |=> O_DIAG_GOING && !O_MODULE_FAULT_LAMP)
    else $error("no going");
  cov_raise: cover property (O_DIAG_INCOMING);
  cov_clear: cover property (O_DIAG_GOING);
  cov_stamp: cover property (I_RD_STB && I_RD_ADDR == 5'h13);
endmodule // idr_diag_record_chk
bind idr_diag_record idr_diag_record_chk u_chk (.I_CLK(I_CLK), .I_RESET(I_RESET),
  .I_MODULE_FAIL(I_MODULE_FAIL), .I_EXT_ERROR(I_EXT_ERROR), .I_LOST_EDGE(I_LOST_EDGE),
  .I_RD_STB(I_RD_STB), .I_RD_ADDR(I_RD_ADDR), .O_RD_DATA(O_RD_DATA),
  .O_RD_VALID(O_RD_VALID), .O_DIAG_INCOMING(O_DIAG_INCOMING), .O_DIAG_GOING(O_DIAG_GOING),
  .O_MODULE_FAULT_LAMP(O_MODULE_FAULT_LAMP), .O_US_TICKER(O_US_TICKER));
`default_nettype wire

// ===== test/idr_host_model.sv
// Purpose: Backplane reader of the record
// Assumes: Answer one edge after the strobe
// Notes:   Released address shows its inverse
`timescale 1ns/1ns
`default_nettype none
module idr_host_model
  import idr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output var  logic       o_rd_stb,
  output var  logic [4:0] o_rd_addr
);
  initial begin
    o_rd_stb  = 1'b0;
    o_rd_addr = 5'h00;
  end
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
    @(negedge i_clk);
    o_rd_stb  = 1'b1;
    o_rd_addr = a;
    @(negedge i_clk);
    o_rd_stb  = 1'b0;
    o_rd_addr = ~a;
    ok        = i_rd_valid;
    d         = i_rd_data;
  endtask
endmodule // idr_host_model
`default_nettype wire

// ===== test/input_diag_record_timestamp_test.sv
// Purpose: Bench of the record tail
// Assumes: Ticker prescale from the package
// Notes:   Wrap is left to the checker
`timescale 1ns/1ns
`default_nettype none
module input_diag_record_timestamp_test
  import idr_pkg::*;
();
  logic clk, rst, mf, ee, stb, vld, inc, going, lamp;
  logic [3:0] le;
  logic [4:0] addr;
  logic [7:0] data;
  logic [31:0] tick;
  int cnt, n_errors, checked;
  idr_diag_record u_dut (.I_CLK(clk), .I_RESET(rst), .I_MODULE_FAIL(mf), .I_EXT_ERROR(ee),
    .I_LOST_EDGE(le), .I_RD_STB(stb), .I_RD_ADDR(addr), .O_RD_DATA(data), .O_RD_VALID(vld),
    .O_DIAG_INCOMING(inc), .O_DIAG_GOING(going), .O_MODULE_FAULT_LAMP(lamp), .O_US_TICKER(tick));
  idr_host_model u_host (.i_clk(clk), .i_rd_data(data), .i_rd_valid(vld), .o_rd_stb(stb),
    .o_rd_addr(addr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cnt <= rst ? 0 : cnt + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string m);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk({31'h0, ok}, 32'h1, "valid");
    chk({24'h0, d}, {24'h0, e}, m);
  endtask
  task automatic t_const;
    rd(5'h00, 8'h00, "summary idle");
    rd(5'h01, VAL_MODULE_INFO, "info");
    rd(5'h02, 8'h00, "rsvd c");
    rd(5'h03, 8'h00, "extra");
    rd(5'h04, VAL_CHANNEL_TYPE, "type");
    rd(5'h05, 8'h00, "bits");
    rd(5'h06, 8'h04, "count");
    rd(5'h07, 8'h00, "flags idle");
    for (int i = 8; i < 32; i++) if (i < 16 || i > 19) rd(5'(i), 8'h00, "rsvd");
    $display("t_const done");
  endtask
  task automatic t_tick;
    repeat (3) begin
      repeat (150) @(negedge clk);
      chk(tick, 32'(cnt / TICK_CYCLES), "ticker");
    end
    $display("t_tick done");
  endtask
  // Cause changes while active must not reach the record
  task automatic t_diag(input logic [5:0] c, input logic [7:0] sum);
    logic [31:0] ts;
    @(negedge clk);
    {mf, ee, le} = c;
    ts = 32'(cnt / TICK_CYCLES);
    @(negedge clk);
    chk({30'h0, inc, lamp}, 32'h3, "incoming");
    le = c[3:0] ^ 4'h5;
    @(negedge clk);
    chk({30'h0, inc, lamp}, 32'h1, "window holds");
    rd(5'h07, {4'h0, c[3:0]}, "flags");
    rd(5'h00, sum, "summary");
    for (int n = 0; n < 4; n++) rd(5'(16 + n), ts[31 - 8 * n -: 8], "stamp");
    {mf, ee, le} = 6'h00;
    @(negedge clk);
    chk({30'h0, going, lamp}, 32'h2, "going");
    rd(5'h07, 8'h00, "flags clear");
    rd(5'h00, 8'h00, "summary clear");
    $display("t_diag done");
  endtask
  task automatic final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {mf, ee, le} = 6'h00;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_const;
    t_tick;
    t_diag(6'b00_1010, 8'h08);
    t_diag(6'b10_0000, 8'h01);
    t_diag(6'b01_0000, 8'h04);
    final_report;
  end
  initial begin
    #100000;
    n_errors++;
    final_report;
  end
endmodule // input_diag_record_timestamp_test
`default_nettype wire
